// File: hdl/temp_limiter.sv
// Summary of operation
// - Below limit, untripped: relays and LEDs on
// - Above limit: relays off, LEDs off
// - Trip released relays: fault output on
// - Trip latched, kept across power loss
// - Clear on reset below limit minus hysteresis
// - Input or internal fault also trips
// - Unlatch only manually, cause gone
// - Power indicator lit after power-up
// - Display variant: set enters blinking adjust
// - Arrows step pending limit
// - Second set press commits pending limit
// - No display: set captures measured value
// - Held test button trips its channel
// - Reset after test restores normal operation
// - Fixed analogue scaling onto loop span
// - Service read of temp, limit, relays
// - Hysteresis defaults to eight kelvin
// - Out of range trips; reset reopens
`timescale 1ns/1ps
`include "limiter_params.svh"
module temp_limiter #(
    parameter int TEST_HOLD_CYC = `TEST_HOLD_CYC,
    parameter int BLINK_CYC = `BLINK_CYC,
    parameter logic [15:0] HYST = `HYST_K
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement, from the front end pins
    input wire logic [15:0] temp_in,
    input wire logic sensor_fault,
    input wire logic internal_fault,
    // Operator pins
    input wire logic reset_button,
    input wire logic channel_one_test_button,
    input wire logic channel_two_test_button,
    // Non-volatile trip store
    input wire logic nv_trip,
    output logic nv_trip_wr,
    // Outputs
    output logic first_output_relay,
    output logic second_output_relay,
    output logic led_relay1,
    output logic led_relay2,
    output logic fault_out,
    output logic power_led,
    output logic blink_on,
    output logic [15:0] analog_temp_ua,
    output logic [15:0] analog_limit_ua
);
    // ************************************
    // Input synchronisers
    // ************************************
    logic [20:0] sa_ff, sb_ff;
    always_ff @(posedge core_clk) begin
        sa_ff <= {temp_in, sensor_fault, internal_fault, reset_button,
            channel_one_test_button, channel_two_test_button};
        sb_ff <= sa_ff;
    end
    limiter_pkg::temp_t temp_s;
    logic sfault, ifault, rbtn, t1, t2;
    assign {temp_s, sfault, ifault, rbtn, t1, t2} = sb_ff;

    // ************************************
    // Register bus
    // ************************************
    logic [4:0] ctrl_ff;
    logic [4:0] ctrl_q_ff;
    logic acc, wr;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff <= 5'h10;
            ctrl_q_ff <= 5'h10;
        end else begin
            ctrl_q_ff <= ctrl_ff;
            if (wr && paddr == `OFS_CTRL)
                ctrl_ff <= pwdata[4:0];
        end
    end
    // Button edges from software-driven button bits
    logic set_p, up_p, dn_p, srst_p, disp_var;
    assign set_p = ctrl_ff[`CTRL_SET_BTN] && !ctrl_q_ff[`CTRL_SET_BTN];
    assign up_p = ctrl_ff[`CTRL_UP_BTN] && !ctrl_q_ff[`CTRL_UP_BTN];
    assign dn_p = ctrl_ff[`CTRL_DN_BTN] && !ctrl_q_ff[`CTRL_DN_BTN];
    assign srst_p = ctrl_ff[`CTRL_RST_BTN] && !ctrl_q_ff[`CTRL_RST_BTN];
    assign disp_var = ctrl_ff[`CTRL_DISP_VAR];

    // External reset button edge
    logic rbtn_q_ff;
    always_ff @(posedge core_clk) rbtn_q_ff <= rbtn;
    logic reset_req;
    assign reset_req = (rbtn && !rbtn_q_ff) || srst_p;

    // ************************************
    // Set value entry
    // ************************************
    limiter_pkg::temp_t limit_ff, pend_ff;
    logic adjust_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            limit_ff <= `LIMIT_RESET;
            pend_ff <= `LIMIT_RESET;
            adjust_ff <= 1'b0;
        end else if (set_p && !disp_var) begin
            limit_ff <= temp_s;
        end else if (set_p && !adjust_ff) begin
            adjust_ff <= 1'b1;
            pend_ff <= limit_ff;
        end else if (set_p) begin
            adjust_ff <= 1'b0;
            limit_ff <= pend_ff;
        end else if (adjust_ff && up_p && pend_ff < `RANGE_MAX) begin
            pend_ff <= pend_ff + 16'sd1;
        end else if (adjust_ff && dn_p && pend_ff > `RANGE_MIN) begin
            pend_ff <= pend_ff - 16'sd1;
        end
    end

    // Blink divider for adjust display
    logic [31:0] blink_cnt_ff;
    always_ff @(posedge core_clk) begin
        if (rst || !adjust_ff) begin
            blink_cnt_ff <= 32'h0;
            blink_on <= 1'b0;
        end else if (blink_cnt_ff == 32'(BLINK_CYC - 1)) begin
            blink_cnt_ff <= 32'h0;
            blink_on <= !blink_on;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
        end
    end

    // ************************************
    // Test buttons
    // ************************************
    logic t1_fire, t2_fire;
    hold_timer #(.HOLD_CYC(TEST_HOLD_CYC)) u_t1 (
        .core_clk(core_clk), .rst(rst), .btn(t1), .fired(t1_fire));
    hold_timer #(.HOLD_CYC(TEST_HOLD_CYC)) u_t2 (
        .core_clk(core_clk), .rst(rst), .btn(t2), .fired(t2_fire));

    // ************************************
    // Trip latch, one per channel
    // ************************************
    logic out_range, over, cleared_ok, any_trip;
    assign out_range = temp_s < `RANGE_MIN || temp_s > `RANGE_MAX;
    assign over = temp_s > limit_ff;
    // Reset needs hysteresis margin and no standing fault
    assign cleared_ok = (temp_s < limit_ff - $signed(HYST)) && !sfault
        && !ifault && !out_range;
    logic [1:0] trip_ff;
    logic loaded_ff;
    logic [1:0] test_fire;
    assign test_fire = {t2_fire, t1_fire};
    // A test button still held is a standing cause for its channel
    logic [1:0] test_held;
    assign test_held = {t2, t1};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic cause;
            // Each channel judges the cause on its own
            assign cause = over || sfault || ifault || out_range
                || test_fire[ch];
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    trip_ff[ch] <= 1'b1;
                end else if (!loaded_ff) begin
                    trip_ff[ch] <= nv_trip;
                end else if (cause) begin
                    trip_ff[ch] <= 1'b1;
                end else if (reset_req && cleared_ok && !test_held[ch]) begin
                    trip_ff[ch] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge core_clk) begin
        if (rst)
            loaded_ff <= 1'b0;
        else
            loaded_ff <= 1'b1;
    end
    assign any_trip = |trip_ff;

    // ************************************
    // Outputs
    // ************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            first_output_relay <= 1'b0;
            second_output_relay <= 1'b0;
            led_relay1 <= 1'b0;
            led_relay2 <= 1'b0;
            fault_out <= 1'b1;
            power_led <= 1'b0;
            nv_trip_wr <= 1'b0;
        end else begin
            // Safety circuit is series: any channel opens both
            first_output_relay <= !any_trip;
            second_output_relay <= !any_trip;
            led_relay1 <= !trip_ff[0] && !any_trip;
            led_relay2 <= !trip_ff[1] && !any_trip;
            fault_out <= any_trip;
            power_led <= 1'b1;
            nv_trip_wr <= loaded_ff ? any_trip : nv_trip;
        end
    end

    // Fixed scaling: 4 mA at -200, 20 mA at 600, 20 uA per kelvin
    function automatic logic [15:0] to_loop(limiter_pkg::temp_t t);
        logic signed [17:0] v;
        v = 18'(t) - 18'(`RANGE_MIN);
        if (v < 0)
            v = 18'sd0;
        if (v > 18'sd800)
            v = 18'sd800;
        return 16'(v * 18'sd20) + `LOOP_MIN_UA;
    endfunction : to_loop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_temp_ua <= `LOOP_MIN_UA;
            analog_limit_ua <= `LOOP_MIN_UA;
        end else begin
            analog_temp_ua <= to_loop(temp_s);
            analog_limit_ua <= to_loop(limit_ff);
        end
    end

    // Register read, one-cycle access phase
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0;
        unique case (paddr)
            `OFS_CTRL: rd = {27'h0, ctrl_ff};
            `OFS_LIMIT: rd = {{16{limit_ff[15]}}, limit_ff};
            `OFS_TEMP: rd = {{16{temp_s[15]}}, temp_s};
            `OFS_STATUS: rd = {24'h0, t2, t1, power_led, adjust_ff,
                fault_out, second_output_relay, first_output_relay,
                any_trip};
            `OFS_ANALOG: rd = {analog_limit_ua, analog_temp_ua};
            default: rd = 32'h0;
        endcase
    end
    logic bad;
    assign bad = paddr != `OFS_CTRL && paddr != `OFS_LIMIT &&
        paddr != `OFS_TEMP && paddr != `OFS_STATUS && paddr != `OFS_ANALOG;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad;
            prdata <= (psel && !penable && !pwrite) ? rd : 32'h0;
        end
    end

    // ************************************
    // Assertions
    // ************************************
    relay_open_a: assert property (@(posedge core_clk) disable iff (rst)
        loaded_ff && over |=> ##1 !first_output_relay && !second_output_relay)
        else $error("relays not opened on over-limit");
    fault_sig_a: assert property (@(posedge core_clk) disable iff (rst)
        !first_output_relay |-> fault_out)
        else $error("fault output missing");
    latch_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        loaded_ff && $past(loaded_ff) && trip_ff[0] && !reset_req
        |=> trip_ff[0])
        else $error("trip dropped without reset");
    unlatch_cond_a: assert property (@(posedge core_clk) disable iff (rst)
        loaded_ff && $past(loaded_ff) && $fell(trip_ff[0])
        |-> $past(reset_req && cleared_ok))
        else $error("unlatched without valid reset");
    fault_trip_a: assert property (@(posedge core_clk) disable iff (rst)
        loaded_ff && (sfault || ifault) |=> trip_ff == 2'h3)
        else $error("fault did not trip");
    test_trip_a: assert property (@(posedge core_clk) disable iff (rst)
        loaded_ff && t1_fire |=> trip_ff[0] ##1 fault_out)
        else $error("test did not trip");
    commit_set_a: assert property (@(posedge core_clk) disable iff (rst)
        adjust_ff && set_p && disp_var
        |=> !adjust_ff && limit_ff == $past(pend_ff))
        else $error("pending value not committed");
    capture_set_a: assert property (@(posedge core_clk) disable iff (rst)
        set_p && !disp_var |=> limit_ff == $past(temp_s))
        else $error("measured value not captured");
    power_led_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(!rst) |-> power_led)
        else $error("power indicator off");
    trip_cv: cover property (@(posedge core_clk) disable iff (rst)
        $rose(fault_out));
    clear_cv: cover property (@(posedge core_clk) disable iff (rst)
        $fell(any_trip));
    adjust_cv: cover property (@(posedge core_clk) disable iff (rst)
        adjust_ff && up_p);
endmodule : temp_limiter

// File: hdl/limiter_params.svh
`ifndef LIMITER_PARAMS_SVH
`define LIMITER_PARAMS_SVH
// Bus offsets
`define OFS_CTRL 12'h000
`define OFS_LIMIT 12'h004
`define OFS_TEMP 12'h008
`define OFS_STATUS 12'h00C
`define OFS_ANALOG 12'h010
// Control register fields
`define CTRL_SET_BTN 0
`define CTRL_UP_BTN 1
`define CTRL_DN_BTN 2
`define CTRL_RST_BTN 3
`define CTRL_DISP_VAR 4
// Status register fields
`define ST_TRIP 0
`define ST_RELAY1 1
`define ST_RELAY2 2
`define ST_FAULT 3
`define ST_ADJUST 4
`define ST_POWER 5
`define ST_CHANNEL_ONE_TEST_BUTTON 6
`define ST_CHANNEL_TWO_TEST_BUTTON 7
// Values, tenths of a degree are not used: whole kelvin, signed
`define LIMIT_RESET 16'h0064
`define HYST_K 16'h0008
`define RANGE_MIN (-16'sd200)
`define RANGE_MAX 16'sd600
`define LOOP_MIN_UA 16'h0FA0
`define LOOP_SPAN_UA 16'h3E80
`define TEST_HOLD_MS 3000
`define CLK_HZ 40000000
`define TEST_HOLD_CYC ((`CLK_HZ / 1000) * `TEST_HOLD_MS)
`define BLINK_CYC 20000000
`endif

// File: hdl/limiter_pkg.sv
package limiter_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_TRIPPED} trip_e;
    typedef logic signed [15:0] temp_t;
endpackage : limiter_pkg

// File: hdl/hold_timer.sv
`timescale 1ns/1ps
`include "limiter_params.svh"
module hold_timer #(
    parameter int HOLD_CYC = `TEST_HOLD_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Synchronised button level
    input wire logic btn,
    // One-cycle pulse once held long enough
    output logic fired
);
    logic [31:0] cnt_ff;
    always_ff @(posedge core_clk) begin
        if (rst || !btn) begin
            cnt_ff <= 32'h0;
            fired <= 1'b0;
        end else begin
            fired <= (cnt_ff == 32'(HOLD_CYC - 1));
            if (cnt_ff != 32'(HOLD_CYC))
                cnt_ff <= cnt_ff + 32'h1;
        end
    end
endmodule : hold_timer

// File: test/op_model.sv
`timescale 1ns/1ps
module op_model #(
    parameter int HOLD = 50
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench request, channel to test
    input wire logic [1:0] test_req,
    // Device pins
    output logic channel_one_test_button,
    output logic channel_two_test_button,
    input wire logic nv_trip_wr,
    output logic nv_trip
);
    int hold_cnt = 0;
    logic [1:0] ch_ff = 2'h0;
    initial nv_trip = 1'b0;
    // Store frozen during rst, as over a mains loss
    always @(posedge core_clk) begin
        if (!rst) begin
            nv_trip <= nv_trip_wr;
        end
        if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end else if (test_req != 2'h0) begin
            hold_cnt <= HOLD + 40;
            ch_ff <= test_req;
        end
    end
    // Only one channel pressed at a time
    assign channel_one_test_button = hold_cnt > 0 && ch_ff == 2'h1;
    assign channel_two_test_button = hold_cnt > 0 && ch_ff == 2'h2;
endmodule : op_model

// File: test/test_latching_temperature_limiter.sv
`timescale 1ns/1ps
`include "limiter_params.svh"
module test_latching_temperature_limiter;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sensor_fault = 1'b0, internal_fault = 1'b0;
    logic reset_button = 1'b0, pready, pslverr, re, nv_trip, nv_trip_wr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic [15:0] temp_in = 16'h0032, analog_temp_ua, analog_limit_ua;
    logic [1:0] test_req = 2'h0;
    logic channel_one_test_button, channel_two_test_button, power_led;
    logic first_output_relay, second_output_relay, led_relay1, led_relay2;
    logic fault_out, blink_on;
    int n_mismatch = 0;
    int tests_run = 0;
    temp_limiter #(.TEST_HOLD_CYC(50), .BLINK_CYC(4), .HYST(16'h0008))
    u_dut (
        .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .temp_in, .sensor_fault,
        .internal_fault, .reset_button, .channel_one_test_button,
        .channel_two_test_button, .nv_trip, .nv_trip_wr,
        .first_output_relay, .second_output_relay, .led_relay1,
        .led_relay2, .fault_out, .power_led, .blink_on, .analog_temp_ua,
        .analog_limit_ua
    );
    op_model #(.HOLD(50)) u_op (
        .core_clk, .rst, .test_req, .channel_one_test_button,
        .channel_two_test_button, .nv_trip_wr, .nv_trip
    );
    initial forever #12.5 core_clk = ~core_clk;
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // No wait limit here: the watchdog ends a hung transfer
        do @(posedge core_clk); while (pready !== 1'b1);
        {re, rq} = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Control bits act on a rising write, so pulse them
    task automatic press(logic [31:0] base, logic [31:0] b);
        apb(1'b1, `OFS_CTRL, base | b);
        apb(1'b1, `OFS_CTRL, base);
    endtask : press
    task automatic push_rst();
        reset_button <= 1'b1;
        cyc(3);
        reset_button <= 1'b0;
        cyc(8);
    endtask : push_rst
    function automatic logic [31:0] pins();
        return {27'h0, first_output_relay, second_output_relay, led_relay1,
                led_relay2, fault_out};
    endfunction : pins
    task automatic t_limit();
        chk(power_led, 1'b1);
        chk(pins(), 32'h1E);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rq[5:0], 6'h26);
        apb(1'b0, 12'h020, 32'h0);
        chk({re, rq[30:0]}, 32'h8000_0000);
        temp_in <= 16'h0065;
        cyc(8);
        chk(pins(), 32'h01);
        chk(nv_trip_wr, 1'b1);
        temp_in <= 16'h005C;
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(8);
        chk(pins(), 32'h01);
        push_rst();
        chk(pins(), 32'h01);
        temp_in <= 16'h005B;
        cyc(3);
        press(32'h10, 32'h08);
        cyc(8);
        chk(pins(), 32'h1E);
        $display("t_limit done");
    endtask : t_limit
    // Causes: sensor, internal, range, test one, test two
    task automatic t_cause();
        for (int f = 0; f < 5; f++) begin
            sensor_fault <= f == 0;
            internal_fault <= f == 1;
            temp_in <= (f == 2) ? 16'hFF37 : 16'h0032;
            test_req <= (f > 2) ? 2'(f - 2) : 2'h0;
            cyc(1);
            test_req <= 2'h0;
            cyc(70);
            chk(pins(), 32'h01);
            push_rst();
            chk(pins(), 32'h01);
            sensor_fault <= 1'b0;
            internal_fault <= 1'b0;
            temp_in <= 16'h0032;
            cyc(20);
            push_rst();
            chk(pins(), 32'h1E);
        end
        $display("t_cause done");
    endtask : t_cause
    task automatic t_setval();
        logic b;
        press(32'h10, 32'h01);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rq[4], 1'b1);
        b = blink_on;
        for (int i = 0; i < 12 && blink_on === b; i++) @(posedge core_clk);
        chk(blink_on, !b);
        repeat (3) press(32'h10, 32'h02);
        press(32'h10, 32'h04);
        press(32'h10, 32'h01);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rq[4], 1'b0);
        apb(1'b0, `OFS_LIMIT, 32'h0);
        chk(rq, 32'h66);
        apb(1'b1, `OFS_CTRL, 32'h0);
        temp_in <= 16'h004D;
        cyc(8);
        press(32'h0, 32'h01);
        temp_in <= 16'h0032;
        cyc(8);
        apb(1'b0, `OFS_ANALOG, 32'h0);
        chk(rq, 32'h2544_2328);
        $display("t_setval done");
    endtask : t_setval
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        cyc(8);
        t_limit();
        t_cause();
        t_setval();
        final_report();
    end
    // Run needs under 2000 cycles; this is ten times that
    initial begin
        #500000;
        n_mismatch++;
        final_report();
    end
endmodule : test_latching_temperature_limiter
